// *** logic/fesc_regs.svh ***
// fesc_regs.svh: command codes, unlock addresses and bus timing for the flash host sequencer
// assumes a 32-bit-wide parallel NOR device and a 50 MHz host clock
`ifndef FESC_REGS_SVH
`define FESC_REGS_SVH

`define FESC_UNLOCK1_ADDR 22'h000555
`define FESC_UNLOCK2_ADDR 22'h0002AA
`define FESC_CFI_ADDR 22'h000055
`define FESC_UNLOCK1_DATA 32'h0000AAAA
`define FESC_UNLOCK2_DATA 32'h00005555
`define FESC_CMD_RESET 32'h0000F0F0
`define FESC_CMD_AUTOSEL 32'h00009090
`define FESC_CMD_OTP_ENTER 32'h00008888
`define FESC_CMD_PROGRAM 32'h0000A0A0
`define FESC_CMD_BUF_LOAD 32'h00002525
`define FESC_CMD_BUF_CONFIRM 32'h00002929
`define FESC_CMD_BYPASS 32'h00002020
`define FESC_CMD_ERASE_SETUP 32'h00008080
`define FESC_CMD_CHIP_ERASE 32'h00001010
`define FESC_CMD_SECTOR_ERASE 32'h00003030
`define FESC_CMD_SUSPEND 32'h0000B0B0
`define FESC_CMD_RESUME 32'h00003030
`define FESC_CMD_CFI 32'h00009898
`define FESC_ZERO_DATA 32'h00000000
`define FESC_OFS_PROTECT 22'h000002
`define FESC_OFS_OTP_LOCK 22'h000003
// strobe phases in ns, converted to cycles at 20 ns per cycle, rounded up
`define FESC_CLK_NS 20
`define FESC_SETUP_NS 40
`define FESC_PULSE_NS 60
`define FESC_HOLD_NS 40
`define FESC_SETUP_CYC ((`FESC_SETUP_NS + `FESC_CLK_NS - 1) / `FESC_CLK_NS)
`define FESC_PULSE_CYC ((`FESC_PULSE_NS + `FESC_CLK_NS - 1) / `FESC_CLK_NS)
`define FESC_HOLD_CYC ((`FESC_HOLD_NS + `FESC_CLK_NS - 1) / `FESC_CLK_NS)
`define FESC_READ_NS 120
`define FESC_READ_CYC ((`FESC_READ_NS + `FESC_CLK_NS - 1) / `FESC_CLK_NS)

`endif

// *** logic/fesc_pkg.sv ***
// fesc_pkg: operation codes and sequencer states of the flash host sequencer
// assumes nothing beyond the regs header for figures
`default_nettype none
package fesc_pkg;
  typedef enum logic [3:0] {
    FESC_OP_RESET = 4'h0,
    FESC_OP_ABORT_RESET = 4'h1,
    FESC_OP_PROGRAM = 4'h2,
    FESC_OP_BUF_PROGRAM = 4'h3,
    FESC_OP_BYPASS_ENTER = 4'h4,
    FESC_OP_BYPASS_PROGRAM = 4'h5,
    FESC_OP_BYPASS_EXIT = 4'h6,
    FESC_OP_OTP_ENTER = 4'h7,
    FESC_OP_OTP_EXIT = 4'h8,
    FESC_OP_AUTOSEL_READ = 4'h9,
    FESC_OP_CHIP_ERASE = 4'hA,
    FESC_OP_SECTOR_ERASE = 4'hB,
    FESC_OP_SUSPEND = 4'hC,
    FESC_OP_RESUME = 4'hD,
    FESC_OP_CFI = 4'hE,
    FESC_OP_READ = 4'hF
  } fesc_op_t;

  typedef enum logic [2:0] {
    FESC_ST_IDLE = 3'h0,
    FESC_ST_PLAN = 3'h1,
    FESC_ST_WRITE = 3'h2,
    FESC_ST_READ = 3'h3,
    FESC_ST_DONE = 3'h4
  } fesc_state_t;

  typedef enum logic [1:0] {
    FESC_ER_NONE = 2'h0,
    FESC_ER_SECTOR = 2'h1,
    FESC_ER_CHIP = 2'h2,
    FESC_ER_SUSPENDED = 2'h3
  } fesc_erase_t;
endpackage : fesc_pkg
`default_nettype wire

// *** logic/fesc_bus_cycle.sv ***
// fesc_bus_cycle: one asynchronous write or read cycle on the flash pins
// assumes the device latches address on the later falling strobe edge, data on the earlier rise
`timescale 1ns/1ns
`default_nettype none
`include "fesc_regs.svh"

module fesc_bus_cycle #(
  parameter int AW = 22,
  parameter int DW = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic is_read,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  input wire logic [DW-1:0] dq_in,
  output logic busy,
  output logic done,
  output logic [DW-1:0] rdata,
  output logic [AW-1:0] a_out,
  output logic [DW-1:0] dq_out,
  output logic dq_oe,
  output logic ce_n,
  output logic we_n,
  output logic oe_n
);
  localparam logic [7:0] SETUP = 8'(`FESC_SETUP_CYC);
  localparam logic [7:0] PULSE = 8'(`FESC_PULSE_CYC);
  localparam logic [7:0] HOLD = 8'(`FESC_HOLD_CYC);
  localparam logic [7:0] RDWAIT = 8'(`FESC_READ_CYC);

  logic [1:0] ph_ff, nxt_ph;
  logic [7:0] cnt_ff, nxt_cnt;
  logic rd_ff, nxt_rd, done_ff, nxt_done;
  logic [AW-1:0] a_ff, nxt_a;
  logic [DW-1:0] d_ff, nxt_d, r_ff, nxt_r;

  //////////////////////////////////////////////////////////////////////////////
  // phases: 0 idle, 1 setup with strobes high, 2 strobe low, 3 hold with strobes high
  always_comb begin
    nxt_ph = ph_ff;
    nxt_cnt = cnt_ff;
    nxt_rd = rd_ff;
    nxt_a = a_ff;
    nxt_d = d_ff;
    nxt_r = r_ff;
    nxt_done = 1'b0;
    unique case (ph_ff)
      2'd0: begin
        if (start) begin
          nxt_ph = 2'd1;
          nxt_cnt = SETUP;
          nxt_rd = is_read;
          nxt_a = addr;
          nxt_d = wdata;
        end
      end
      2'd1: begin
        if (cnt_ff <= 8'h01) begin
          nxt_ph = 2'd2;
          nxt_cnt = rd_ff ? RDWAIT : PULSE;
        end else begin
          nxt_cnt = cnt_ff - 8'h01;
        end
      end
      2'd2: begin
        if (cnt_ff <= 8'h01) begin
          // data stays driven past the rising edge so the device latches it stable
          nxt_ph = 2'd3;
          nxt_cnt = HOLD;
          if (rd_ff) begin
            nxt_r = dq_in;
          end
        end else begin
          nxt_cnt = cnt_ff - 8'h01;
        end
      end
      2'd3: begin
        if (cnt_ff <= 8'h01) begin
          nxt_ph = 2'd0;
          nxt_done = 1'b1;
        end else begin
          nxt_cnt = cnt_ff - 8'h01;
        end
      end
    endcase
  end

  // state registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ph_ff <= 2'd0;
      cnt_ff <= 8'h00;
      rd_ff <= 1'b0;
      a_ff <= '0;
      d_ff <= '0;
      r_ff <= '0;
      done_ff <= 1'b0;
    end else begin
      ph_ff <= nxt_ph;
      cnt_ff <= nxt_cnt;
      rd_ff <= nxt_rd;
      a_ff <= nxt_a;
      d_ff <= nxt_d;
      r_ff <= nxt_r;
      done_ff <= nxt_done;
    end
  end

  // pin drive, strobes gated from phase and read-flag registers only
  logic strobe_ff;
  logic act_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strobe_ff <= 1'b0;
      act_ff <= 1'b0;
    end else begin
      strobe_ff <= (nxt_ph == 2'd2);
      act_ff <= (nxt_ph != 2'd0);
    end
  end

  assign busy = (ph_ff != 2'd0);
  assign done = done_ff;
  assign rdata = r_ff;
  assign a_out = a_ff;
  assign dq_out = d_ff;
  assign dq_oe = act_ff & ~rd_ff;
  assign ce_n = ~act_ff;
  assign we_n = ~(strobe_ff & ~rd_ff);
  assign oe_n = ~(strobe_ff & rd_ff);
endmodule // fesc_bus_cycle

`default_nettype wire

// *** logic/fesc_host.sv ***
// fesc_host: host-side command sequencer that drives a 32-bit parallel NOR flash
// assumes requests arrive synchronous to SYS_CLK and the device answers on its pins
//
// Contract
// - erase suspend is only sent while sector erase or its time-out runs
// - resume is sent once; a new suspend only after erasing resumes
// - every unlocked sequence starts with the two unlock writes
// - buffer program: load code, count, address/data pairs, confirm
// - abort reset is unlock pair plus reset code, three cycles
// - bypass entry three cycles, then two-cycle bypass program
// - bypass exit: exit code then zero word, any address
// - secured region entry: unlock pair plus entry code
// - secured region exit: unlock pair, query code, zero word
// - suspend and resume are single writes at any address
// - one-cycle reset leaves autoselect or clears an error
// - the buffer count written is locations minus one
`timescale 1ns/1ns
`default_nettype none
`include "fesc_regs.svh"

module fesc_host #(
  parameter int AW = 22,
  parameter int DW = 32,
  parameter int BUF_MAX = 16,
  parameter int SUSPEND_WAIT_US = 20
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic REQ_VALID,
  input wire fesc_pkg::fesc_op_t REQ_OP,
  input wire logic [AW-1:0] REQ_ADDR,
  input wire logic [DW-1:0] REQ_DATA,
  input wire logic [4:0] REQ_COUNT,
  input wire logic ERASE_DONE,
  output logic REQ_READY,
  output logic RSP_VALID,
  output logic [DW-1:0] RSP_DATA,
  output logic BUF_NEXT,
  output logic SUSPENDED,
  output logic [AW-1:0] FLASH_A,
  output logic [DW-1:0] FLASH_DQ_O,
  output logic FLASH_DQ_OE,
  input wire logic [DW-1:0] FLASH_DQ_I,
  output logic FLASH_CE_N,
  output logic FLASH_WE_N,
  output logic FLASH_OE_N
);
  import fesc_pkg::*;

  localparam int WAIT_CYC = SUSPEND_WAIT_US * 1000 / `FESC_CLK_NS;
  localparam logic [AW-1:0] U1 = `FESC_UNLOCK1_ADDR;
  localparam logic [AW-1:0] U2 = `FESC_UNLOCK2_ADDR;

  fesc_state_t st_ff, nxt_st;
  fesc_erase_t er_ff, nxt_er;
  fesc_op_t op_ff, nxt_op;
  logic [AW-1:0] addr_ff, nxt_addr;
  logic [DW-1:0] data_ff, nxt_data;
  logic [4:0] cnt_ff, nxt_cnt;
  logic [4:0] step_ff, nxt_step;
  logic [4:0] last_ff, nxt_last;
  logic [15:0] wait_ff, nxt_wait;
  logic rsp_ff, nxt_rsp, bufn_ff, nxt_bufn, rdy_ff, nxt_rdy;
  logic [DW-1:0] rdat_ff, nxt_rdat;

  logic cyc_start, cyc_read, cyc_busy, cyc_done;
  logic [AW-1:0] cyc_addr;
  logic [DW-1:0] cyc_wdata, cyc_rdata;

  //////////////////////////////////////////////////////////////////////////////
  // legality of a request against the tracked erase state
  function automatic logic op_legal(input fesc_op_t op, input fesc_erase_t er);
    unique case (op)
      FESC_OP_SUSPEND: op_legal = (er == FESC_ER_SECTOR);
      FESC_OP_RESUME: op_legal = (er == FESC_ER_SUSPENDED);
      FESC_OP_READ, FESC_OP_PROGRAM, FESC_OP_AUTOSEL_READ, FESC_OP_RESET:
        op_legal = (er != FESC_ER_CHIP) && (er != FESC_ER_SECTOR || op == FESC_OP_READ);
      default: op_legal = (er == FESC_ER_NONE);
    endcase
  endfunction

  // address and data of write number s of the current sequence
  always_comb begin
    cyc_addr = U1;
    cyc_wdata = `FESC_UNLOCK1_DATA;
    cyc_read = 1'b0;
    if (step_ff == 5'd1) begin
      cyc_addr = U2;
      cyc_wdata = `FESC_UNLOCK2_DATA;
    end
    unique case (op_ff)
      FESC_OP_RESET, FESC_OP_SUSPEND, FESC_OP_RESUME: begin
        cyc_addr = addr_ff;
        cyc_wdata = (op_ff == FESC_OP_SUSPEND) ? `FESC_CMD_SUSPEND :
                    (op_ff == FESC_OP_RESUME) ? `FESC_CMD_RESUME : `FESC_CMD_RESET;
      end
      FESC_OP_CFI: begin
        cyc_addr = `FESC_CFI_ADDR;
        cyc_wdata = `FESC_CMD_CFI;
      end
      FESC_OP_READ: begin
        cyc_addr = addr_ff;
        cyc_read = 1'b1;
      end
      FESC_OP_BYPASS_PROGRAM, FESC_OP_BYPASS_EXIT: begin
        cyc_addr = addr_ff;
        cyc_wdata = (op_ff == FESC_OP_BYPASS_EXIT) ? `FESC_CMD_AUTOSEL : `FESC_CMD_PROGRAM;
        if (step_ff == 5'd1) begin
          cyc_wdata = (op_ff == FESC_OP_BYPASS_EXIT) ? `FESC_ZERO_DATA : data_ff;
        end
      end
      default: begin
        if (step_ff == 5'd2) begin
          unique case (op_ff)
            FESC_OP_ABORT_RESET: cyc_wdata = `FESC_CMD_RESET;
            FESC_OP_PROGRAM: cyc_wdata = `FESC_CMD_PROGRAM;
            FESC_OP_BYPASS_ENTER: cyc_wdata = `FESC_CMD_BYPASS;
            FESC_OP_OTP_ENTER: cyc_wdata = `FESC_CMD_OTP_ENTER;
            FESC_OP_BUF_PROGRAM: begin
              cyc_addr = addr_ff;
              cyc_wdata = `FESC_CMD_BUF_LOAD;
            end
            FESC_OP_CHIP_ERASE, FESC_OP_SECTOR_ERASE: cyc_wdata = `FESC_CMD_ERASE_SETUP;
            default: cyc_wdata = `FESC_CMD_AUTOSEL;
          endcase
        end else if (step_ff >= 5'd3) begin
          unique case (op_ff)
            FESC_OP_PROGRAM: begin
              cyc_addr = addr_ff;
              cyc_wdata = data_ff;
            end
            FESC_OP_OTP_EXIT: cyc_wdata = `FESC_ZERO_DATA;
            FESC_OP_AUTOSEL_READ: begin
              cyc_addr = addr_ff;
              cyc_read = 1'b1;
            end
            FESC_OP_BUF_PROGRAM: begin
              cyc_addr = addr_ff;
              if (step_ff == 5'd3) begin
                cyc_wdata = {{(DW-5){1'b0}}, cnt_ff};
              end else if (step_ff == last_ff) begin
                cyc_wdata = `FESC_CMD_BUF_CONFIRM;
              end else begin
                cyc_wdata = REQ_DATA;
                cyc_addr = REQ_ADDR;
              end
            end
            default: begin
              // erase: second unlock pair then the final code
              if (step_ff == 5'd4) begin
                cyc_addr = U2;
                cyc_wdata = `FESC_UNLOCK2_DATA;
              end else if (step_ff == 5'd5) begin
                cyc_addr = (op_ff == FESC_OP_SECTOR_ERASE) ? addr_ff : U1;
                cyc_wdata = (op_ff == FESC_OP_SECTOR_ERASE) ? `FESC_CMD_SECTOR_ERASE :
                            `FESC_CMD_CHIP_ERASE;
              end
            end
          endcase
        end
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // sequencer: one request becomes a run of bus cycles
  always_comb begin
    nxt_st = st_ff;
    nxt_er = er_ff;
    nxt_op = op_ff;
    nxt_addr = addr_ff;
    nxt_data = data_ff;
    nxt_cnt = cnt_ff;
    nxt_step = step_ff;
    nxt_last = last_ff;
    nxt_wait = wait_ff;
    nxt_rsp = 1'b0;
    nxt_bufn = 1'b0;
    nxt_rdy = 1'b0;
    nxt_rdat = rdat_ff;
    cyc_start = 1'b0;
    // erase completion reported by status polling outside
    if (ERASE_DONE && (er_ff == FESC_ER_SECTOR || er_ff == FESC_ER_CHIP)) begin
      nxt_er = FESC_ER_NONE;
    end
    unique case (st_ff)
      FESC_ST_IDLE: begin
        nxt_rdy = 1'b1;
        if (REQ_VALID && rdy_ff) begin
          nxt_rdy = 1'b0;
          nxt_op = REQ_OP;
          nxt_addr = REQ_ADDR;
          nxt_data = REQ_DATA;
          nxt_cnt = REQ_COUNT;
          nxt_step = 5'd0;
          nxt_st = op_legal(REQ_OP, er_ff) ? FESC_ST_PLAN : FESC_ST_DONE;
        end
      end
      FESC_ST_PLAN: begin
        unique case (op_ff)
          FESC_OP_RESET, FESC_OP_SUSPEND, FESC_OP_RESUME, FESC_OP_CFI, FESC_OP_READ: begin
            nxt_step = 5'd16; // single cycle, no unlock
            nxt_last = 5'd16;
          end
          FESC_OP_BYPASS_PROGRAM, FESC_OP_BYPASS_EXIT: nxt_last = 5'd1;
          FESC_OP_ABORT_RESET, FESC_OP_BYPASS_ENTER, FESC_OP_OTP_ENTER: nxt_last = 5'd2;
          FESC_OP_PROGRAM, FESC_OP_OTP_EXIT, FESC_OP_AUTOSEL_READ: nxt_last = 5'd3;
          FESC_OP_BUF_PROGRAM: nxt_last = 5'(cnt_ff + 5'd5); // unlock pair, load, count, pairs, confirm
          default: nxt_last = 5'd5;
        endcase
        nxt_st = FESC_ST_WRITE;
      end
      FESC_ST_WRITE: begin
        if (!cyc_busy) begin
          cyc_start = 1'b1;
          nxt_st = FESC_ST_READ;
          if (op_ff == FESC_OP_BUF_PROGRAM && step_ff >= 5'd4 && step_ff != last_ff) begin
            nxt_bufn = 1'b1; // word consumed from REQ_DATA
          end
        end
      end
      FESC_ST_READ: begin
        if (cyc_done) begin
          nxt_rdat = cyc_rdata;
          if (step_ff == last_ff) begin
            nxt_st = FESC_ST_DONE;
            nxt_wait = 16'h0000;
            if (op_ff == FESC_OP_SUSPEND) begin
              nxt_wait = 16'(WAIT_CYC);
            end
          end else begin
            nxt_step = 5'(step_ff + 5'd1);
            nxt_st = FESC_ST_WRITE;
          end
        end
      end
      FESC_ST_DONE: begin
        if (wait_ff != 16'h0000) begin
          nxt_wait = 16'(wait_ff - 16'h0001);
        end else begin
          nxt_rsp = 1'b1;
          nxt_st = FESC_ST_IDLE;
          if (op_legal(op_ff, er_ff)) begin
            unique case (op_ff)
              FESC_OP_SECTOR_ERASE: nxt_er = FESC_ER_SECTOR;
              FESC_OP_CHIP_ERASE: nxt_er = FESC_ER_CHIP;
              FESC_OP_SUSPEND: nxt_er = FESC_ER_SUSPENDED;
              FESC_OP_RESUME: nxt_er = FESC_ER_SECTOR;
              default: nxt_er = nxt_er;
            endcase
          end
        end
      end
      default: nxt_st = FESC_ST_IDLE;
    endcase
  end

  // registers of the sequencer
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      st_ff <= FESC_ST_IDLE;
      er_ff <= FESC_ER_NONE;
      op_ff <= FESC_OP_RESET;
      addr_ff <= '0;
      data_ff <= '0;
      cnt_ff <= 5'h00;
      step_ff <= 5'h00;
      last_ff <= 5'h00;
      wait_ff <= 16'h0000;
      rsp_ff <= 1'b0;
      bufn_ff <= 1'b0;
      rdy_ff <= 1'b0;
      rdat_ff <= '0;
    end else begin
      st_ff <= nxt_st;
      er_ff <= nxt_er;
      op_ff <= nxt_op;
      addr_ff <= nxt_addr;
      data_ff <= nxt_data;
      cnt_ff <= nxt_cnt;
      step_ff <= nxt_step;
      last_ff <= nxt_last;
      wait_ff <= nxt_wait;
      rsp_ff <= nxt_rsp;
      bufn_ff <= nxt_bufn;
      rdy_ff <= nxt_rdy;
      rdat_ff <= nxt_rdat;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin cycle engine
  fesc_bus_cycle #(.AW(AW), .DW(DW)) u_cycle (
    .clk(SYS_CLK),
    .rst(RST),
    .start(cyc_start),
    .is_read(cyc_read),
    .addr(cyc_addr),
    .wdata(cyc_wdata),
    .dq_in(FLASH_DQ_I),
    .busy(cyc_busy),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .a_out(FLASH_A),
    .dq_out(FLASH_DQ_O),
    .dq_oe(FLASH_DQ_OE),
    .ce_n(FLASH_CE_N),
    .we_n(FLASH_WE_N),
    .oe_n(FLASH_OE_N)
  );

  assign REQ_READY = rdy_ff;
  assign RSP_VALID = rsp_ff;
  assign RSP_DATA = rdat_ff;
  assign BUF_NEXT = bufn_ff;
  assign SUSPENDED = (er_ff == FESC_ER_SUSPENDED);

  //////////////////////////////////////////////////////////////////////////////
  // checks
  a_suspend_legal: assert property (@(posedge SYS_CLK) disable iff (RST)
    (st_ff == FESC_ST_PLAN && op_ff == FESC_OP_SUSPEND) |-> $past(er_ff) == FESC_ER_SECTOR)
    else $error("suspend issued outside sector erase");
  a_strobe_exclusive: assert property (@(posedge SYS_CLK) disable iff (RST)
    !(!FLASH_WE_N && !FLASH_OE_N))
    else $error("write and read strobes low together");
  a_write_drives: assert property (@(posedge SYS_CLK) disable iff (RST)
    $fell(FLASH_WE_N) |=> FLASH_DQ_OE && $stable(FLASH_DQ_O) && $stable(FLASH_A))
    else $error("data or address moved during write strobe");
  a_resume_state: assert property (@(posedge SYS_CLK) disable iff (RST)
    (st_ff == FESC_ST_DONE && wait_ff == 16'h0000 && op_ff == FESC_OP_RESUME && SUSPENDED)
    |=> er_ff == FESC_ER_SECTOR)
    else $error("resume did not restart erase");
  a_chip_refuse: assert property (@(posedge SYS_CLK) disable iff (RST)
    (REQ_VALID && REQ_READY && REQ_OP == FESC_OP_SUSPEND && er_ff == FESC_ER_CHIP)
    |=> st_ff == FESC_ST_DONE) else $error("suspend taken in chip erase");
  a_halt_wait: assert property (@(posedge SYS_CLK) disable iff (RST)
    (cyc_done && op_ff == FESC_OP_SUSPEND) |=> !RSP_VALID [*8]) else $error("suspend answered early");
endmodule // fesc_host

`default_nettype wire

// *** tb/fesc_flash_model.sv ***
// fesc_flash_model: behavioural x32 flash device as seen at its pins
// assumes one host drives the strobes; the device has no clock of its own
`timescale 1ns/1ns
`default_nettype none

module fesc_flash_model #(
  parameter logic [31:0] LOCK_WORD = 32'h00005A5A // arbitrary lock indicator value
) (
  input wire logic [21:0] a,
  input wire logic [31:0] dq_o,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  output logic [31:0] dq_i,
  output logic wr_tgl,
  output logic [21:0] wr_a,
  output logic [31:0] wr_d
);
  logic in_wr = 1'b0;
  logic asel = 1'b0;
  logic ul1 = 1'b0;
  logic ul2 = 1'b0;
  initial wr_tgl = 1'b0;
  initial dq_i = 32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // read data: id words in query mode, an address-derived word otherwise
  function automatic logic [31:0] rd_word(input logic [21:0] ra, input logic q);
    if (q && ra[7:0] == 8'h02) return ra[15] ? 32'h00000101 : 32'h00000000;
    if (q && ra[7:0] == 8'h03) return LOCK_WORD;
    return {ra[15:0] ^ 16'hC3A5, ra[15:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // address on the later falling strobe
  always @(negedge we_n or negedge ce_n) begin
    if (!we_n && !ce_n) begin
      wr_a = a;
      in_wr = 1'b1;
    end
  end

  // data on the earlier rising strobe; tracks the query mode too
  always @(posedge we_n or posedge ce_n) begin
    if (in_wr) begin
      in_wr = 1'b0;
      wr_d = dq_o;
      if (wr_d[15:0] == 16'hF0F0 || wr_d[15:0] == 16'h0000) asel = 1'b0;
      else if (ul2 && wr_a == 22'h000555 && wr_d[15:0] == 16'h9090) asel = 1'b1;
      ul2 = ul1 && wr_a == 22'h0002AA && wr_d[15:0] == 16'h5555;
      ul1 = wr_a == 22'h000555 && wr_d[15:0] == 16'hAAAA;
      wr_tgl = ~wr_tgl;
    end
  end

  // released bus flips on every change so a stale word never passes as data
  always @(a or ce_n or oe_n) begin
    if (!ce_n && !oe_n) dq_i = rd_word(a, asel);
    else dq_i = ~dq_i;
  end
endmodule // fesc_flash_model

`default_nettype wire

// *** tb/fesc_host_tb.sv ***
// fesc_host_tb: self-checking bench for the flash host sequencer
// assumes fesc_flash_model on the pins and a 50 MHz clock
`timescale 1ns/1ns
`default_nettype none

module fesc_host_tb;
  import fesc_pkg::*;
  localparam logic [31:0] LOCK = 32'h00005A5A; // arbitrary lock indicator value
  localparam logic [21:0] U1 = 22'h000555;
  localparam logic [21:0] F = 22'h3FFFFF;
  localparam logic [21:0] S = 22'h3F8000; // sector bits only
  localparam logic [21:0] X = 22'h000000; // address not looked at
  logic SYS_CLK = 1'b0;
  logic RST = 1'b1;
  logic REQ_VALID = 1'b0;
  fesc_op_t REQ_OP = FESC_OP_READ;
  logic [21:0] REQ_ADDR = 22'h000000;
  logic [31:0] REQ_DATA = 32'h00000000;
  logic [4:0] REQ_COUNT = 5'h00;
  logic ERASE_DONE = 1'b0;
  logic REQ_READY, RSP_VALID, BUF_NEXT, SUSPENDED, ce_n, we_n, oe_n, dq_oe, wr_tgl;
  logic [21:0] flash_a, wr_a;
  logic [31:0] RSP_DATA, dq_o, dq_i, wr_d;
  integer seed = 32'h881012E4;
  int mismatches = 0;
  int n_tests = 0;
  int er = 0; // 0 idle, 1 sector erase, 2 chip erase, 3 suspended
  bit asel = 1'b0;
  int bi = 0;
  logic bn = 1'b0;
  logic [21:0] pa [0:32];
  logic [31:0] pd [0:32];
  logic [21:0] exp_a [$], exp_m [$], got_a [$];
  logic [31:0] exp_d [$], got_d [$];

  always #10 SYS_CLK = ~SYS_CLK;

  fesc_host #(.SUSPEND_WAIT_US(1)) dut (.SYS_CLK(SYS_CLK), .RST(RST), .REQ_VALID(REQ_VALID),
    .REQ_OP(REQ_OP), .REQ_ADDR(REQ_ADDR), .REQ_DATA(REQ_DATA), .REQ_COUNT(REQ_COUNT),
    .ERASE_DONE(ERASE_DONE), .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID),
    .RSP_DATA(RSP_DATA), .BUF_NEXT(BUF_NEXT), .SUSPENDED(SUSPENDED), .FLASH_A(flash_a),
    .FLASH_DQ_O(dq_o), .FLASH_DQ_OE(dq_oe), .FLASH_DQ_I(dq_i), .FLASH_CE_N(ce_n),
    .FLASH_WE_N(we_n), .FLASH_OE_N(oe_n));
  fesc_flash_model #(.LOCK_WORD(LOCK)) flash (.a(flash_a), .dq_o(dq_o), .ce_n(ce_n),
    .we_n(we_n), .oe_n(oe_n), .dq_i(dq_i), .wr_tgl(wr_tgl), .wr_a(wr_a), .wr_d(wr_d));

  ////////////////////////////////////////////////////////////////////////////
  // write cycles seen by the device, and buffer pairs handed on request
  always @(wr_tgl) begin
    got_a.push_back(wr_a);
    got_d.push_back(wr_d);
  end
  always @(negedge SYS_CLK) bn = BUF_NEXT;
  always @(posedge SYS_CLK) begin
    if (bn === 1'b1) begin
      bi <= bi + 1;
      REQ_ADDR <= pa[bi + 1];
      REQ_DATA <= pd[bi + 1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic push(input logic [21:0] a, input logic [21:0] m, input logic [31:0] d);
    exp_a.push_back(a);
    exp_m.push_back(m);
    exp_d.push_back(d);
  endtask

  task automatic unl;
    push(U1, F, 32'h0000AAAA);
    push(22'h0002AA, F, 32'h00005555);
  endtask

  function automatic logic [31:0] rd_exp(input logic [21:0] a);
    if (asel && a[7:0] == 8'h02) return a[15] ? 32'h00000101 : 32'h00000000;
    if (asel && a[7:0] == 8'h03) return LOCK;
    return {a[15:0] ^ 16'hC3A5, a[15:0]};
  endfunction

  // one request: build the expected cycles, issue, wait, compare
  task automatic do_op(input fesc_op_t op, input logic [21:0] a, input logic [31:0] d,
      input int n, input bit ok);
    int k;
    exp_a.delete();
    exp_m.delete();
    exp_d.delete();
    if (ok) begin
      case (op)
        FESC_OP_RESET: push(a, X, 32'h0000F0F0);
        FESC_OP_ABORT_RESET: begin unl(); push(U1, F, 32'h0000F0F0); end
        FESC_OP_PROGRAM: begin unl(); push(U1, F, 32'h0000A0A0); push(a, F, d); end
        FESC_OP_BUF_PROGRAM: begin
          unl();
          push(a, S, 32'h00002525);
          push(a, S, {27'h0000000, n[4:0]});
          for (k = 0; k <= n; k++) push(pa[k], F, pd[k]);
          push(a, S, 32'h00002929);
        end
        FESC_OP_BYPASS_ENTER: begin unl(); push(U1, F, 32'h00002020); end
        FESC_OP_BYPASS_PROGRAM: begin push(a, X, 32'h0000A0A0); push(a, F, d); end
        FESC_OP_BYPASS_EXIT: begin push(a, X, 32'h00009090); push(a, X, 32'h00000000); end
        FESC_OP_OTP_ENTER: begin unl(); push(U1, F, 32'h00008888); end
        FESC_OP_OTP_EXIT: begin unl(); push(U1, F, 32'h00009090); push(a, X, 32'h00000000); end
        FESC_OP_AUTOSEL_READ: begin unl(); push(U1, F, 32'h00009090); end
        FESC_OP_CHIP_ERASE: begin
          unl(); push(U1, F, 32'h00008080); unl(); push(U1, F, 32'h00001010);
        end
        FESC_OP_SECTOR_ERASE: begin
          unl(); push(U1, F, 32'h00008080); unl(); push(a, S, 32'h00003030);
        end
        FESC_OP_SUSPEND: push(a, X, 32'h0000B0B0);
        FESC_OP_RESUME: push(a, X, 32'h00003030);
        FESC_OP_CFI: push(22'h000055, F, 32'h00009898);
        default: ;
      endcase
    end
    @(posedge SYS_CLK);
    got_a.delete();
    got_d.delete();
    bi <= 0;
    REQ_OP <= op;
    REQ_ADDR <= a;
    REQ_DATA <= d;
    REQ_COUNT <= n[4:0];
    REQ_VALID <= 1'b1;
    k = 0;
    do begin @(negedge SYS_CLK); k++; end while (REQ_READY !== 1'b1 && k < 3000);
    @(posedge SYS_CLK);
    REQ_VALID <= 1'b0;
    k = 0;
    do begin @(negedge SYS_CLK); k++; end while (RSP_VALID !== 1'b1 && k < 3000);
    chk(k < 3000, 1'b1);
    if (ok) begin
      case (op)
        FESC_OP_AUTOSEL_READ: asel = 1'b1;
        FESC_OP_RESET, FESC_OP_ABORT_RESET: asel = 1'b0;
        FESC_OP_SECTOR_ERASE, FESC_OP_RESUME: er = 1;
        FESC_OP_CHIP_ERASE: er = 2;
        FESC_OP_SUSPEND: er = 3;
        default: ;
      endcase
    end
    chk(got_a.size(), exp_a.size());
    for (k = 0; k < exp_a.size() && k < got_a.size(); k++) begin
      chk(got_a[k] & exp_m[k], exp_a[k] & exp_m[k]);
      chk(got_d[k], exp_d[k]);
    end
    if (op == FESC_OP_READ || op == FESC_OP_AUTOSEL_READ) chk(RSP_DATA, rd_exp(a));
    chk(SUSPENDED, er == 3);
  endtask

  task automatic fin_erase;
    @(posedge SYS_CLK);
    ERASE_DONE <= 1'b1;
    @(posedge SYS_CLK);
    ERASE_DONE <= 1'b0;
    er = 0;
  endtask

  task automatic report_and_stop;
    if (mismatches == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // watchdog: the whole run needs well under 10k cycles
  initial begin
    #2000000;
    mismatches++;
    report_and_stop();
  end

  initial begin
    fesc_op_t ops [10] = '{FESC_OP_RESET, FESC_OP_PROGRAM, FESC_OP_ABORT_RESET,
      FESC_OP_BYPASS_ENTER, FESC_OP_BYPASS_PROGRAM, FESC_OP_BYPASS_EXIT, FESC_OP_OTP_ENTER,
      FESC_OP_OTP_EXIT, FESC_OP_CFI, FESC_OP_READ};
    logic [31:0] r;
    logic [31:0] d;
    repeat (6) @(posedge SYS_CLK);
    RST <= 1'b0;
    do_op(FESC_OP_SUSPEND, X, '0, 0, 0);
    do_op(FESC_OP_RESUME, X, '0, 0, 0);
    foreach (ops[i]) begin
      r = $random(seed);
      d = $random(seed);
      do_op(ops[i], r[21:0], d, 0, 1);
    end
    // buffer loads of one to sixteen locations
    for (int n = 0; n < 16; n += 5) begin
      r = $random(seed);
      for (int k = 0; k <= n; k++) begin
        pa[k] = {r[21:4], 4'h0} + 22'(k);
        pd[k] = $random(seed);
      end
      pa[n + 1] = pa[0];
      pd[n + 1] = pd[0];
      do_op(FESC_OP_BUF_PROGRAM, pa[0], pd[0], n, 1);
    end
    do_op(FESC_OP_AUTOSEL_READ, 22'h008002, '0, 0, 1);
    do_op(FESC_OP_AUTOSEL_READ, 22'h010002, '0, 0, 1);
    do_op(FESC_OP_AUTOSEL_READ, 22'h000003, '0, 0, 1);
    do_op(FESC_OP_RESET, X, '0, 0, 1);
    do_op(FESC_OP_READ, 22'h012345, '0, 0, 1);
    do_op(FESC_OP_SECTOR_ERASE, 22'h018000, '0, 0, 1);
    do_op(FESC_OP_PROGRAM, 22'h020010, 32'h12345678, 0, 0);
    do_op(FESC_OP_SUSPEND, X, '0, 0, 1);
    do_op(FESC_OP_PROGRAM, 22'h020010, 32'h12345678, 0, 1);
    do_op(FESC_OP_READ, 22'h020010, '0, 0, 1);
    do_op(FESC_OP_AUTOSEL_READ, 22'h028002, '0, 0, 1);
    do_op(FESC_OP_RESET, X, '0, 0, 1);
    do_op(FESC_OP_RESUME, X, '0, 0, 1);
    do_op(FESC_OP_RESUME, X, '0, 0, 0);
    do_op(FESC_OP_SUSPEND, X, '0, 0, 1);
    do_op(FESC_OP_RESUME, X, '0, 0, 1);
    fin_erase();
    do_op(FESC_OP_CHIP_ERASE, X, '0, 0, 1);
    do_op(FESC_OP_SUSPEND, X, '0, 0, 0);
    fin_erase();
    do_op(FESC_OP_READ, 22'h03ABCD, '0, 0, 1);
    report_and_stop();
  end
endmodule // fesc_host_tb

`default_nettype wire
